//--- pkg/i2c_ext_pkg.sv
// Functional notes
// - extension code interrupt shows 0010X010B
// - 8-clock wait data byte shows 0010X000B
// - 9-clock wait code acknowledge shows 0010X110B
// - 9-clock wait first data shows 0010X100B
// - 9-clock wait last data shows 0010XX00B
// - stop shows 00000001B, interrupt if enabled
// - 8-clock restart with code repeats sequence
// - 8-clock restart mismatch clears code flag
// - 9-clock restart mismatch, then no data interrupts
// - 9-clock restart with code repeats sequence
// - 9-clock final data shows 0010XX00B
// - arbitration lost in code: 0110X010B, stay slave
// - upper nibble 0000/1111 flags code at clock 8
// - wait timing bit picks clock 8 or 9 for data; code also waits at 9 if set
package i2c_ext_pkg;

	// register offsets (byte addresses, one word each)
	localparam logic [7:0] OFF_CTRL = 8'h00;
	localparam logic [7:0] OFF_STATUS = 8'h04;
	localparam logic [7:0] OFF_DATA = 8'h08;
	localparam logic [7:0] OFF_OWN_ADDR = 8'h0C;
	localparam logic [7:0] OFF_IRQ_STATUS = 8'h10;
	localparam logic [7:0] OFF_IRQ_CLEAR = 8'h14;
	localparam logic [7:0] OFF_IRQ_ENABLE = 8'h18;

	// control register fields
	localparam int CTRL_WAIT_TIMING = 0;
	localparam int CTRL_STOP_IRQ_EN = 1;
	localparam int CTRL_WAIT_RELEASE = 2;
	localparam int CTRL_ACK_ENABLE = 3;
	localparam logic [3:0] CTRL_RESET = 4'h0;

	// status register fields
	localparam int ST_MASTER = 7;
	localparam int ST_ARB_LOST = 6;
	localparam int ST_EXT_CODE = 5;
	localparam int ST_ADDR_MATCH = 4;
	localparam int ST_TRANSMIT = 3;
	localparam int ST_ACK_DET = 2;
	localparam int ST_START_DET = 1;
	localparam int ST_STOP_DET = 0;
	localparam logic [7:0] STATUS_RESET = 8'h00;
	localparam logic [7:0] STATUS_STOP = 8'h01;

	// interrupt status fields
	localparam int IRQ_XFER = 0;
	localparam int IRQ_STOP = 1;
	localparam int IRQ_BITS = 2;

	// byte framing on the bus
	localparam logic [3:0] CNT_DATA_END = 4'h8;
	localparam logic [3:0] CNT_ACK_END = 4'h9;
	localparam logic [3:0] EXT_LOW_NIBBLE = 4'h0;
	localparam logic [3:0] EXT_HIGH_NIBBLE = 4'hF;
	localparam logic [7:0] OWN_ADDR_RESET = 8'h00;
	localparam int SYNC_STAGES = 3;

	typedef struct packed {
		logic [7:0] addr;
		logic [31:0] wdata;
		logic wr;
		logic rd;
	} reg_req_s;

	typedef enum logic [1:0] {
		PH_IDLE,
		PH_ADDR,
		PH_DATA,
		PH_IGNORE
	} phase_e;

endpackage : i2c_ext_pkg

//--- hdl/pin_sync3.sv
`timescale 1ns/1ns
module pin_sync3 #(
	parameter int WIDTH = 2
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic [WIDTH-1:0] pin,
	input wire logic [WIDTH-1:0] init,
	output logic [WIDTH-1:0] level
);
	import i2c_ext_pkg::*;

	logic [WIDTH-1:0] s1;
	logic [WIDTH-1:0] s2;
	logic [WIDTH-1:0] s3;

	// first stage feeds only the second; a bit counts once stages two and three agree
	// reset loads the idle pin level, so no false edge follows reset
	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			s1 <= init;
			s2 <= init;
			s3 <= init;
		end
		else
		begin
			s1 <= pin;
			s2 <= s1;
			s3 <= s2;
		end
	end

	// filtered level, bits update independently
	always_ff @(posedge clk)
	begin
		if (!rst_n)
			level <= init;
		else
			level <= (~(s2 ^ s3) & s3) | ((s2 ^ s3) & level);
	end

endmodule : pin_sync3

//--- hdl/i2c_ext_code_slave_status.sv
`timescale 1ns/1ns
module i2c_ext_code_slave_status #(
	parameter int DATA_W = 32
) (
	input wire logic clk,
	input wire logic rst_n,
	input i2c_ext_pkg::reg_req_s reg_req,
	output logic [DATA_W-1:0] rd_data,
	input wire logic scl_in,
	output logic scl_out,
	output logic scl_oe,
	input wire logic sda_in,
	output logic sda_out,
	output logic sda_oe,
	input wire logic arb_lost,
	output logic serial_bus_irq
);
	import i2c_ext_pkg::*;

	// narrower read data could not carry the status byte
	if (DATA_W < 8)
	begin : g_width_check
		$error("DATA_W must be at least 8");
	end

	function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
		hit = (a == off);
	endfunction : hit

	function automatic logic is_ext_code(input logic [7:0] b);
		is_ext_code = (b[7:4] == EXT_LOW_NIBBLE) || (b[7:4] == EXT_HIGH_NIBBLE);
	endfunction : is_ext_code

	logic [1:0] pins;
	logic scl_s;
	logic sda_s;
	logic scl_d;
	logic sda_d;
	logic scl_rise;
	logic scl_fall;
	logic start_det;
	logic stop_det;
	logic [3:0] ctrl;
	logic [7:0] own_address_reg;
	logic [7:0] bus_status_reg;
	logic [7:0] shift_data_reg;
	logic [3:0] bit_cnt;
	phase_e phase;
	logic restart;
	logic ack_slot;
	logic wait_hold;
	logic xfer_ev;
	logic stop_ev;
	logic [IRQ_BITS-1:0] irq_status;
	logic [IRQ_BITS-1:0] irq_enable;
	logic wr_ctrl;
	logic wr_data;
	logic rd_status;
	logic sw_release;
	logic want_ack;
	logic pin_low;

	// bus pins pass the three-stage filter before any edge logic sees them
	pin_sync3 #(.WIDTH(2)) u_sync (
		.clk(clk),
		.rst_n(rst_n),
		.pin({scl_in, sda_in}),
		.init(2'h3),
		.level(pins)
	);
	assign scl_s = pins[1];
	assign sda_s = pins[0];

	// previous filtered levels for edge detection
	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			scl_d <= 1'b1;
			sda_d <= 1'b1;
		end
		else
		begin
			scl_d <= scl_s;
			sda_d <= sda_s;
		end
	end

	// start and stop are sda edges while scl stays high
	assign scl_rise = scl_s & ~scl_d;
	assign scl_fall = ~scl_s & scl_d;
	assign start_det = scl_s & scl_d & sda_d & ~sda_s;
	assign stop_det = scl_s & scl_d & ~sda_d & sda_s;

	// register strobes
	assign wr_ctrl = reg_req.wr & hit(reg_req.addr, OFF_CTRL);
	assign wr_data = reg_req.wr & hit(reg_req.addr, OFF_DATA);
	assign rd_status = reg_req.rd & hit(reg_req.addr, OFF_STATUS);
	assign sw_release = (wr_ctrl & reg_req.wdata[CTRL_WAIT_RELEASE]) | wr_data;

	// control and own address registers; wait release bit is not stored
	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			ctrl <= CTRL_RESET;
			own_address_reg <= OWN_ADDR_RESET;
		end
		else
		begin
			if (wr_ctrl)
			begin
				ctrl <= reg_req.wdata[3:0];
				ctrl[CTRL_WAIT_RELEASE] <= 1'b0;
			end
			if (reg_req.wr && hit(reg_req.addr, OFF_OWN_ADDR))
				own_address_reg <= reg_req.wdata[7:0];
		end
	end

	// bus protocol, wait control and status flags
	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			phase <= PH_IDLE;
			bit_cnt <= 4'h0;
			shift_data_reg <= 8'h00;
			bus_status_reg <= STATUS_RESET;
			wait_hold <= 1'b0;
			ack_slot <= 1'b0;
			restart <= 1'b0;
			xfer_ev <= 1'b0;
			stop_ev <= 1'b0;
		end
		else
		begin
			xfer_ev <= 1'b0;
			stop_ev <= 1'b0;
			if (sw_release)
				wait_hold <= 1'b0;
			if (wr_data)
				shift_data_reg <= reg_req.wdata[7:0];
			// reading status clears arbitration loss, a new loss wins
			if (rd_status)
				bus_status_reg[ST_ARB_LOST] <= 1'b0;
			if (arb_lost)
				bus_status_reg[ST_ARB_LOST] <= 1'b1;
			if (start_det)
			begin
				bus_status_reg[ST_START_DET] <= 1'b1;
				bus_status_reg[ST_STOP_DET] <= 1'b0;
				bus_status_reg[ST_ACK_DET] <= 1'b0;
				bus_status_reg[ST_MASTER] <= 1'b0;
				restart <= (phase != PH_IDLE);
				phase <= PH_ADDR;
				bit_cnt <= 4'h0;
				ack_slot <= 1'b0;
				wait_hold <= 1'b0;
			end
			else if (stop_det)
			begin
				bus_status_reg <= STATUS_STOP;
				stop_ev <= ctrl[CTRL_STOP_IRQ_EN];
				phase <= PH_IDLE;
				bit_cnt <= 4'h0;
				ack_slot <= 1'b0;
				wait_hold <= 1'b0;
			end
			else if (scl_rise && phase != PH_IDLE)
			begin
				if (bit_cnt < CNT_DATA_END)
					shift_data_reg <= {shift_data_reg[6:0], sda_s};
				if (bit_cnt == CNT_DATA_END)
					bus_status_reg[ST_ACK_DET] <= ~sda_s;
				// start and ack flags fall at the first clock of a data byte
				if (phase == PH_DATA && bit_cnt == 4'h0)
				begin
					bus_status_reg[ST_START_DET] <= 1'b0;
					bus_status_reg[ST_ACK_DET] <= 1'b0;
				end
				bit_cnt <= bit_cnt + 4'h1;
			end
			else if (scl_fall && phase != PH_IDLE)
			begin
				if (bit_cnt == CNT_DATA_END)
				begin
					ack_slot <= 1'b1;
					if (phase == PH_ADDR)
					begin
						if (is_ext_code(shift_data_reg))
						begin
							// code interrupt at clock 8 whatever the wait timing
							bus_status_reg[ST_EXT_CODE] <= 1'b1;
							bus_status_reg[ST_ADDR_MATCH] <= 1'b0;
							xfer_ev <= 1'b1;
							wait_hold <= 1'b1;
						end
						else
						begin
							bus_status_reg[ST_EXT_CODE] <= 1'b0;
							bus_status_reg[ST_ADDR_MATCH] <=
								(shift_data_reg[7:1] == own_address_reg[7:1]);
						end
					end
					else if (phase == PH_DATA && !ctrl[CTRL_WAIT_TIMING])
					begin
						xfer_ev <= 1'b1;
						wait_hold <= 1'b1;
					end
				end
				else if (bit_cnt == CNT_ACK_END)
				begin
					ack_slot <= 1'b0;
					bit_cnt <= 4'h0;
					if (phase == PH_ADDR)
					begin
						if (bus_status_reg[ST_EXT_CODE])
						begin
							phase <= PH_DATA;
							if (ctrl[CTRL_WAIT_TIMING])
							begin
								xfer_ev <= 1'b1;
								wait_hold <= 1'b1;
							end
						end
						else if (bus_status_reg[ST_ADDR_MATCH])
						begin
							phase <= PH_DATA;
							xfer_ev <= 1'b1;
							wait_hold <= 1'b1;
						end
						else
						begin
							// mismatch: after a restart report once, never wait
							phase <= PH_IGNORE;
							xfer_ev <= restart;
						end
					end
					else if (phase == PH_DATA && ctrl[CTRL_WAIT_TIMING])
					begin
						xfer_ev <= 1'b1;
						wait_hold <= 1'b1;
					end
				end
			end
			bus_status_reg[ST_TRANSMIT] <= 1'b0;
		end
	end

	// ack wanted: address match always, code or data only if enabled
	always_comb
	begin
		case (phase)
			PH_ADDR:
				want_ack = bus_status_reg[ST_ADDR_MATCH] |
					(bus_status_reg[ST_EXT_CODE] & ctrl[CTRL_ACK_ENABLE]);
			PH_DATA:
				want_ack = ctrl[CTRL_ACK_ENABLE];
			default:
				want_ack = 1'b0;
		endcase
	end

	// open-drain drivers; ack follows enable even during a wait, scl is low then
	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			scl_oe <= 1'b0;
			sda_oe <= 1'b0;
			pin_low <= 1'b0;
		end
		else
		begin
			scl_oe <= wait_hold;
			sda_oe <= ack_slot & want_ack & ~start_det & ~stop_det;
			pin_low <= 1'b0;
		end
	end
	assign scl_out = pin_low;
	assign sda_out = pin_low;

	// sticky interrupt status, set wins over a clear in the same cycle
	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			irq_status <= '0;
			irq_enable <= '0;
			serial_bus_irq <= 1'b0;
		end
		else
		begin
			if (reg_req.wr && hit(reg_req.addr, OFF_IRQ_ENABLE))
				irq_enable <= reg_req.wdata[IRQ_BITS-1:0];
			irq_status <= (irq_status & ~({IRQ_BITS{reg_req.wr &&
				hit(reg_req.addr, OFF_IRQ_CLEAR)}} & reg_req.wdata[IRQ_BITS-1:0]))
				| {stop_ev, xfer_ev};
			serial_bus_irq <= |(irq_status & irq_enable);
		end
	end

	// read data stands only in the cycle after the read strobe
	always_ff @(posedge clk)
	begin
		if (!rst_n)
			rd_data <= '0;
		else
		begin
			rd_data <= '0;
			if (reg_req.rd)
			begin
				case (reg_req.addr)
					OFF_CTRL: rd_data[3:0] <= ctrl;
					OFF_STATUS: rd_data[7:0] <= bus_status_reg;
					OFF_DATA: rd_data[7:0] <= shift_data_reg;
					OFF_OWN_ADDR: rd_data[7:0] <= own_address_reg;
					OFF_IRQ_STATUS: rd_data[IRQ_BITS-1:0] <= irq_status;
					OFF_IRQ_ENABLE: rd_data[IRQ_BITS-1:0] <= irq_enable;
					default: rd_data <= '0;
				endcase
			end
		end
	end

endmodule : i2c_ext_code_slave_status

//--- dv/i2c_ext_properties.sv
`timescale 1ns/1ns
module i2c_ext_checker (
	input wire logic clk,
	input wire logic rst_n,
	input i2c_ext_pkg::reg_req_s reg_req,
	input wire logic [31:0] rd_data,
	input wire logic scl_in,
	input wire logic scl_out,
	input wire logic scl_oe,
	input wire logic sda_in,
	input wire logic sda_out,
	input wire logic sda_oe,
	input wire logic arb_lost,
	input wire logic serial_bus_irq
);
	import i2c_ext_pkg::*;
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rst_n);
	// software actions that end a wait or drop the interrupt
	sequence bit_release;
		reg_req.wr && reg_req.addr == OFF_CTRL && reg_req.wdata[CTRL_WAIT_RELEASE];
	endsequence
	sequence data_write;
		reg_req.wr && reg_req.addr == OFF_DATA;
	endsequence
	sequence irq_clear;
		reg_req.wr && reg_req.addr == OFF_IRQ_CLEAR && reg_req.wdata == 32'h3;
	endsequence
	// open drain: a high pin level would fight the pull-up
	a_scl_only_low: assert property (scl_out == 1'b0)
		else $error("scl output driven high");
	a_sda_only_low: assert property (sda_out == 1'b0)
		else $error("sda output driven high");
	a_read_one_cycle: assert property (rd_data != 32'h0 |-> $past(reg_req.rd))
		else $error("read data outside its cycle");
	// the hold may only start in the low phase of the clock
	a_wait_on_low: assert property ($rose(scl_oe) |-> $past(!scl_in))
		else $error("clock hold began while scl high");
	a_ack_on_low: assert property ($rose(sda_oe) |-> $past(!scl_in))
		else $error("ack began while scl high");
	a_ack_stands: assert property (sda_oe && scl_in |=> sda_oe)
		else $error("ack dropped while scl high");
	a_bit_release: assert property (bit_release |-> ##2 !scl_oe)
		else $error("wait kept after release bit");
	a_data_release: assert property (data_write |-> ##2 !scl_oe)
		else $error("wait kept after data write");
	a_irq_clear: assert property (irq_clear |-> ##2 !serial_bus_irq)
		else $error("interrupt kept after clear");
endmodule : i2c_ext_checker
bind i2c_ext_code_slave_status i2c_ext_checker chk (.clk(clk), .rst_n(rst_n), .reg_req(reg_req),
	.rd_data(rd_data), .scl_in(scl_in), .scl_out(scl_out), .scl_oe(scl_oe), .sda_in(sda_in),
	.sda_out(sda_out), .sda_oe(sda_oe), .arb_lost(arb_lost), .serial_bus_irq(serial_bus_irq));

//--- dv/i2c_master_model.sv
`timescale 1ns/1ns
module i2c_master_model (
	input wire logic scl_line,
	output logic scl_drv,
	output logic sda_drv
);
	// released lines rise through the pull-ups
	initial {scl_drv, sda_drv} = 2'b11;
	// system clock rises 25 ns into each 50 ns step; keep pin moves between rises
	task automatic align();
		#((50 - $time % 50) % 50);
	endtask : align
	// release scl, follow a slave that stretches it, then step off the sample edges
	task automatic release_scl();
		scl_drv = 1'b1;
		wait (scl_line);
		align();
	endtask : release_scl
	// 300 ns low phase outlasts the slave's grab of scl at an interrupt point
	task automatic pulse(input logic b);
		#100 sda_drv = b;
		#200 release_scl();
		#100 scl_drv = 1'b0;
	endtask : pulse
	// 9'h100 start or restart, 9'h1FF stop, else a byte msb first and an open ack slot
	// longer low phase before a start lets the slave drop its ack first
	task automatic play(input logic [8:0] q[$]);
		align();
		foreach (q[k])
			if (q[k][8])
			begin
				#100 sda_drv = !q[k][0];
				#300 release_scl();
				#200 sda_drv = q[k][0];
				if (!q[k][0])
					#200 scl_drv = 1'b0;
			end
			else
			begin
				for (int i = 7; i >= 0; i--)
					pulse(q[k][i]);
				pulse(1'b1);
			end
	endtask : play
endmodule : i2c_master_model

//--- dv/test_i2c_ext_code_slave_status.sv
`timescale 1ns/1ns
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin fail_count++; \
	$display("Error %0t: got %h want %h", $time, a, b); end end
module test_i2c_ext_code_slave_status;
	import i2c_ext_pkg::*;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic arb_lost = 1'b0;
	reg_req_s reg_req = '0;
	logic [31:0] rd_data;
	logic scl_out, scl_oe, sda_out, sda_oe, serial_bus_irq;
	wire m_scl, m_sda;
	int fail_count = 0;
	int cmp_count = 0;
	int cyc = 0;
	logic [31:0] got;
	logic [3:0] ctrl;
	// pull-ups: the line is low while either party pulls it
	wire scl_in = m_scl & !scl_oe;
	wire sda_in = m_sda & !sda_oe;
	always #25 clk = ~clk;
	i2c_ext_code_slave_status dut (.clk(clk), .rst_n(rst_n), .reg_req(reg_req), .rd_data(rd_data),
		.scl_in(scl_in), .scl_out(scl_out), .scl_oe(scl_oe), .sda_in(sda_in), .sda_out(sda_out),
		.sda_oe(sda_oe), .arb_lost(arb_lost), .serial_bus_irq(serial_bus_irq));
	i2c_master_model master (.scl_line(scl_in), .scl_drv(m_scl), .sda_drv(m_sda));
	// register bus cycles, strobes held for one edge
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		reg_req <= '{a, d, 1'b1, 1'b0};
		@(posedge clk);
		reg_req.wr <= 1'b0;
	endtask : wr
	task automatic rd(input logic [7:0] a);
		@(posedge clk);
		reg_req <= '{a, 32'h0, 1'b0, 1'b1};
		@(posedge clk);
		reg_req.rd <= 1'b0;
		@(posedge clk);
		got = rd_data;
	endtask : rd
	// e = {release by data write, status, mask of cared bits}
	task automatic serve(input logic [16:0] e);
		int n = 0;
		while (serial_bus_irq !== 1'b1 && n < 3000)
		begin
			@(posedge clk);
			n++;
		end
		`CHK(serial_bus_irq, 1'b1)
		rd(OFF_STATUS);
		`CHK(got[7:0] & e[7:0], e[15:8])
		wr(OFF_IRQ_CLEAR, 32'h3);
		wr(e[16] ? OFF_DATA : OFF_CTRL, {28'h0, ctrl | 4'h4});
		repeat (2) @(posedge clk);
	endtask : serve
	// master traffic and software service run side by side
	task automatic run(input logic [8:0] m[$], input logic [16:0] s[$]);
		fork
			master.play(m);
			foreach (s[k])
				serve(s[k]);
		join
	endtask : run
	task automatic cfg(input logic [3:0] v);
		ctrl = v;
		wr(OFF_CTRL, {28'h0, v});
	endtask : cfg
	task automatic eight_clock_flow();
		cfg(4'hA);
		wr(OFF_OWN_ADDR, 32'hA0);
		run('{9'h100, 9'h08, 9'h5A, 9'h100, 9'hF0, 9'hC3, 9'h100, 9'h52, 9'h3C, 9'h1FF}, '{
			17'h022F7,
			17'h120F7,
			17'h022F7,
			17'h120F7,
			17'h002FB,
			17'h001FF});
		rd(OFF_OWN_ADDR);
		`CHK(got, 32'hA0)
	endtask : eight_clock_flow
	task automatic nine_clock_flow();
		cfg(4'hB);
		run('{9'h100, 9'h0A, 9'h11, 9'h22, 9'h100, 9'hFE, 9'h33, 9'h100, 9'h52, 9'h44,
			9'h1FF}, '{
			17'h022F7,
			17'h026F7,
			17'h124F7,
			17'h020F3,
			17'h022F7,
			17'h026F7,
			17'h120F3,
			17'h002FB,
			17'h001FF});
	endtask : nine_clock_flow
	// arbitration lost mid code, stop interrupt disabled
	task automatic arb_flow();
		cfg(4'h8);
		fork
			run('{9'h100, 9'h0F, 9'h77, 9'h1FF}, '{
				17'h062F7,
				17'h120F7});
			begin
				repeat (40) @(posedge clk);
				arb_lost <= 1'b1;
				@(posedge clk);
				arb_lost <= 1'b0;
			end
		join
		repeat (50) @(posedge clk);
		`CHK(serial_bus_irq, 1'b0)
		rd(OFF_IRQ_STATUS);
		`CHK(got, 32'h0)
		rd(OFF_STATUS);
		`CHK(got[7:0], 8'h01)
	endtask : arb_flow
	task automatic stop_test();
		$display("compares %0d errors %0d", cmp_count, fail_count);
		if (fail_count == 0 && cmp_count > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask : stop_test
	// hang guard, far beyond the fewer than two thousand cycles needed
	always @(posedge clk)
	begin
		cyc++;
		if (cyc == 20000)
		begin
			fail_count++;
			$display("Error %0t: run timed out", $time);
			stop_test();
		end
	end
	initial
	begin
		repeat (6) @(posedge clk);
		rst_n <= 1'b1;
		repeat (5) @(posedge clk);
		rd(OFF_STATUS);
		`CHK(got, 32'h0)
		rd(8'h1C);
		`CHK(got, 32'h0)
		wr(OFF_IRQ_ENABLE, 32'h3);
		eight_clock_flow();
		nine_clock_flow();
		arb_flow();
		stop_test();
	end
endmodule : test_i2c_ext_code_slave_status
